/* verilog/sbf_framer_map.svh */
`ifndef SBF_FRAMER_MAP_SVH
`define SBF_FRAMER_MAP_SVH

// block geometry: 64 scrambled data bits behind a two-bit header
`define SBF_DATA_W      7'h40
`define SBF_BLK_W       7'h42
`define SBF_HDR_W       7'h02
// multiblock geometry: 32 blocks, so a 5-bit index wraps naturally
`define SBF_LAST_BLK    5'h1F
`define SBF_FIRST_BLK   5'h00
`define SBF_FIRST_MB    5'h00
// header pair patterns, first bit in position 0
`define SBF_PAIR_ONE    2'h2
`define SBF_PAIR_ZERO   2'h1
// sync header format select codes
`define SBF_SHM_CRC12   2'h0
`define SBF_SHM_FEC     2'h2
// parity generator: x^12 term implied, feedback taps x^9 x^8 x^3 x^2 x 1
`define SBF_CRC_POLY    12'h30F
`define SBF_CRC_CLR     12'h000
`define SBF_FEC_CLR     26'h0000000
// sync header stream bit positions
`define SBF_POS_EOEMB   5'h16
`define SBF_POS_CMD6    5'h10
`define SBF_POS_PILOT0  5'h1B
`define SBF_POS_PILOT3  5'h1E
`define SBF_POS_PILOT4  5'h1F
// multiblock-end pilot 00001 and the fixed ones of the parity format
`define SBF_PILOT_TAIL  5'h10
`define SBF_CRC_ONES    32'h80A88888

`endif

/* verilog/sbf_pkg.sv */
package sbf_pkg;
  // alignment state, gray coded along free -> locked
  typedef enum logic [1:0] {
    SBF_ST_FREE = 2'b00,
    SBF_ST_LOCK = 2'b01
  } sbf_state_t;
endpackage

/* verilog/sbf_block_framer.sv */
`include "sbf_framer_map.svh"

module sbf_block_framer
  import sbf_pkg::*;
(
  input  wire logic        i_mclk,                        // lane word clock
  input  wire logic        i_rst_n,                       // async reset, active low
  input  wire logic        i_sysref,                      // sysref pin, asynchronous
  input  wire logic [63:0] i_blk_data,                    // scrambled block, octet 0 in [63:56]
  input  wire logic        i_blk_valid,                   // one block offered this cycle
  input  wire logic [1:0]  i_sync_header_format_select,   // 0 parity-12, 2 error correction
  input  wire logic [4:0]  i_emb_size_e,                  // E minus one, multiblocks per extended
  input  wire logic [25:0] i_fec_parity,                  // parity word from the external encoder
  output logic      [65:0] o_blk,                         // framed block, bit 0 sent first
  output logic             o_blk_valid,                   // o_blk holds a new block
  output logic      [4:0]  o_blk_index,                   // block index within multiblock
  output logic      [4:0]  o_mb_index,                    // multiblock index within extended
  output logic             o_lemc_pulse,                  // first block of an extended multiblock
  output logic             o_aligned                      // timing reset by sysref at least once
);

  // ---------------- functions ----------------

  // one block through the parity generator, data MSB first (serial order)
  function automatic logic [11:0] crc12_blk(input logic [11:0] seed, input logic [63:0] data);
    logic [11:0] s;
    logic        fb;
    s = seed;
    for (int k = 63; k >= 0; k--) begin
      fb = s[11] ^ data[k];
      s  = {s[10:0], 1'b0} ^ (fb ? `SBF_CRC_POLY : `SBF_CRC_CLR);
    end
    return s;
  endfunction

  // assemble a 32-bit stream word for the chosen format
  function automatic logic [31:0] shs_word(input logic        fec_mode,
                                           input logic [11:0] crc,
                                           input logic [25:0] fec,
                                           input logic        eoemb);
    logic [31:0] w;
    w = 32'h00000000;
    if (fec_mode) begin
      for (int i = 0; i < 22; i++) begin
        w[i] = fec[25-i];
      end
      for (int i = 0; i < 4; i++) begin
        w[23+i] = fec[3-i];
      end
    end else begin
      w = `SBF_CRC_ONES;
      for (int g = 0; g < 4; g++) begin
        for (int j = 0; j < 3; j++) begin
          w[4*g+j] = crc[11-3*g-j];
        end
      end
      // command positions 16-18, 20, 24-26 stay zero
    end
    w[`SBF_POS_EOEMB] = eoemb;
    w[`SBF_POS_PILOT4:`SBF_POS_PILOT0] = `SBF_PILOT_TAIL;
    return w;
  endfunction

  // header pair then octets, serial bit n lands in o_blk[n]
  function automatic logic [65:0] pack_block(input logic hbit, input logic [63:0] data);
    logic [65:0] b;
    b[1:0] = hbit ? `SBF_PAIR_ONE : `SBF_PAIR_ZERO;
    for (int i = 0; i < 64; i++) begin
      b[2+i] = data[63-i];
    end
    return b;
  endfunction

  // ---------------- sysref synchroniser ----------------
  logic       sref_s1_r;   // metastability stage, read by stage two only
  logic       sref_s2_r;   // second stage
  logic       sref_s3_r;   // third stage
  logic       sref_lvl_r;  // accepted level, moves when stages two and three agree

  // three-flop pin synchroniser
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sref_s1_r <= 1'b0;
      sref_s2_r <= 1'b0;
      sref_s3_r <= 1'b0;
    end else begin
      sref_s1_r <= i_sysref;
      sref_s2_r <= sref_s1_r;
      sref_s3_r <= sref_s2_r;
    end
  end

  wire sref_agree = (sref_s2_r == sref_s3_r);
  wire sref_edge  = sref_agree && sref_s3_r && !sref_lvl_r;  // one pulse per sysref rise

  // filtered level, guards against a single-cycle glitch
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sref_lvl_r <= 1'b0;
    end else if (sref_agree) begin
      sref_lvl_r <= sref_s3_r;
    end
  end

  // ---------------- block and multiblock timing ----------------
  logic [4:0]  blk_cnt_r;    // index the next accepted block gets
  logic [4:0]  mb_cnt_r;     // multiblock index of the next block
  logic [1:0]  shm_r;        // format held for the running multiblock
  logic [11:0] crc_r;        // running parity of the current multiblock
  logic [11:0] crc_hold_r;   // parity of the previous multiblock, on air now
  logic [25:0] fec_hold_r;   // external parity for the previous multiblock
  sbf_state_t  state_r;      // alignment state

  // a sysref edge forces the arriving block to block 0 of multiblock 0
  wire [4:0] blk_idx  = sref_edge ? `SBF_FIRST_BLK : blk_cnt_r;
  wire [4:0] mb_idx   = sref_edge ? `SBF_FIRST_MB : mb_cnt_r;
  wire       mb_first = (blk_idx == `SBF_FIRST_BLK);
  wire       mb_last  = (blk_idx == `SBF_LAST_BLK);
  wire       emb_last = (mb_idx == i_emb_size_e);
  wire [4:0] blk_nxt  = blk_idx + 5'h01;                                 // 32 wraps to 0
  wire [4:0] mb_nxt   = emb_last ? `SBF_FIRST_MB : mb_idx + 5'h01;

  // unsupported codes fall back to the parity-12 format
  wire [1:0] shm_in   = (i_sync_header_format_select == `SBF_SHM_FEC) ? `SBF_SHM_FEC
                                                                      : `SBF_SHM_CRC12;
  // format only changes on a multiblock boundary so a stream word is never mixed
  wire [1:0] shm_cur  = mb_first ? shm_in : shm_r;
  wire       fec_mode = (shm_cur == `SBF_SHM_FEC);

  // parity clears at each multiblock start, headers are never fed in
  wire [11:0] crc_seed = mb_first ? `SBF_CRC_CLR : crc_r;
  wire [11:0] crc_nxt  = crc12_blk(crc_seed, i_blk_data);
  wire [31:0] shs_cur  = shs_word(fec_mode, crc_hold_r, fec_hold_r, emb_last);
  wire        hdr_bit  = shs_cur[blk_idx];
  wire [65:0] blk_nxt_w = pack_block(hdr_bit, i_blk_data);

  // counters advance per accepted block; sysref alone just rephases them
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blk_cnt_r <= `SBF_FIRST_BLK;
      mb_cnt_r  <= `SBF_FIRST_MB;
    end else if (i_blk_valid) begin
      blk_cnt_r <= blk_nxt;
      mb_cnt_r  <= mb_last ? mb_nxt : mb_idx;
    end else if (sref_edge) begin
      blk_cnt_r <= `SBF_FIRST_BLK;
      mb_cnt_r  <= `SBF_FIRST_MB;
    end
  end

  // parity accumulate and hand-over at the multiblock end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      crc_r      <= `SBF_CRC_CLR;
      crc_hold_r <= `SBF_CRC_CLR;
      fec_hold_r <= `SBF_FEC_CLR;
      shm_r      <= `SBF_SHM_CRC12;
    end else if (i_blk_valid) begin
      crc_r <= crc_nxt;
      shm_r <= shm_cur;
      if (mb_last) begin
        crc_hold_r <= crc_nxt;
        fec_hold_r <= i_fec_parity;
      end
    end
  end

  // alignment state: locked from the first sysref onward
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= SBF_ST_FREE;
    end else begin
      case (state_r)
        SBF_ST_FREE: state_r <= sref_edge ? SBF_ST_LOCK : SBF_ST_FREE;
        SBF_ST_LOCK: state_r <= SBF_ST_LOCK;
        default:     state_r <= SBF_ST_FREE;
      endcase
    end
  end

  // ---------------- output registers ----------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_blk        <= {64'h0000000000000000, `SBF_PAIR_ZERO};  // pair in bits 1:0, a legal header even while idle
      o_blk_valid  <= 1'b0;
      o_blk_index  <= `SBF_FIRST_BLK;
      o_mb_index   <= `SBF_FIRST_MB;
      o_lemc_pulse <= 1'b0;
    end else begin
      o_blk_valid  <= i_blk_valid;
      o_lemc_pulse <= i_blk_valid && mb_first && (mb_idx == `SBF_FIRST_MB);
      if (i_blk_valid) begin
        o_blk       <= blk_nxt_w;
        o_blk_index <= blk_idx;
        o_mb_index  <= mb_idx;
      end
    end
  end

  assign o_aligned = (state_r == SBF_ST_LOCK);

  // ---------------- assertions ----------------
  sequence s_blk_in;
    i_blk_valid && !sref_edge;
  endsequence

  // block 0 of a parity-format multiblock carries the top parity bit of the last one
  sequence s_mb_start_crc;
    i_blk_valid && mb_first && !fec_mode;
  endsequence

  property p_hdr_compl;
    @(posedge i_mclk) disable iff (!i_rst_n)
      o_blk_valid |-> (o_blk[0] != o_blk[1]);
  endproperty

  a_hdr_compl:     assert property (p_hdr_compl) else $error("header pair not complementary");

  a_data_order:    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_blk_valid |=> (o_blk[2] == $past(i_blk_data[63])) && (o_blk[65] == $past(i_blk_data[0])))
    else $error("octet bits out of serial order");

  a_pilot_one:     assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_blk_valid && o_blk_index == `SBF_LAST_BLK) |-> (o_blk[1:0] == `SBF_PAIR_ONE))
    else $error("pilot last bit not one");

  a_pilot_zero:    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_blk_valid && o_blk_index >= `SBF_POS_PILOT0 && o_blk_index <= `SBF_POS_PILOT3)
      |-> (o_blk[1:0] == `SBF_PAIR_ZERO))
    else $error("pilot zero bit wrong");

  a_eoemb_bit:     assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_blk_valid && o_blk_index == `SBF_POS_EOEMB)
      |-> (o_blk[1] == (o_mb_index == $past(i_emb_size_e))))
    else $error("end of extended multiblock bit wrong");

  a_cmd_zero:      assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_blk_valid && blk_idx == `SBF_POS_CMD6 && !fec_mode) |=> (o_blk[1:0] == `SBF_PAIR_ZERO))
    else $error("command bit not zero");

  a_crc_carry:     assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_mb_start_crc |=> (o_blk[1] == $past(crc_hold_r[11])))
    else $error("parity not carried into next multiblock");

  a_crc_clear:     assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_blk_valid && mb_first) |=> (crc_r == crc12_blk(`SBF_CRC_CLR, $past(i_blk_data))))
    else $error("parity not cleared at multiblock start");

  a_sysref_phase:  assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (sref_edge && i_blk_valid) |=> (o_blk_index == `SBF_FIRST_BLK) && (o_mb_index == `SBF_FIRST_MB)
      && o_lemc_pulse && o_aligned)
    else $error("sysref did not rephase timing");

  a_blk_step:      assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_blk_in |=> (o_blk_index == $past(blk_cnt_r)) && (blk_cnt_r == $past(blk_cnt_r) + 5'h01))
    else $error("block index did not step");

endmodule

/* dv/sbf_dv_pkg.sv */
package sbf_dv_pkg;
  // serial parity-12 update, d[63] enters first; one bit at a time keeps it obviously right
  function automatic logic [11:0] sbf_crc_step(input logic [11:0] c, input logic [63:0] d);
    logic fb;
    for (int i = 63; i >= 0; i--) begin
      fb = c[11] ^ d[i];
      c  = {c[10:0], 1'b0} ^ (fb ? 12'h30F : 12'h000);
    end
    return c;
  endfunction
endpackage

/* dv/sbf_rx_model.sv */
module sbf_rx_model
  import sbf_dv_pkg::*;
(
  input  wire logic        i_mclk,      // lane word clock
  input  wire logic        i_rst_n,     // async reset, active low
  input  wire logic [65:0] i_blk,       // block as seen on the line, bit 0 first
  input  wire logic        i_blk_valid, // new block on the line
  input  wire logic [4:0]  i_blk_index, // block position, stands in for a real boundary search
  input  wire logic        i_crc_mode,  // configured receive format is parity-12
  output logic      [31:0] o_word,      // last complete header stream word
  output logic             o_hdr_bad,   // sticky: a 00 or 11 pair was seen
  output logic             o_crc_err    // sticky: carried parity disagreed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] sh_r;       // header bits of the multiblock in progress
  logic [11:0] crc_r;      // running parity over line data
  logic [11:0] crc_prev_r; // parity of the last finished multiblock
  logic [31:0] w_nxt;      // stream word including this block
  logic [11:0] c_nxt;      // parity including this block
  logic [11:0] rx_crc;     // parity field carried in the stream
  logic [63:0] line_d;     // data in line order, first bit at the top

  // bit n of the stream is the pair of block n, position 1 holds the conveyed value
  assign w_nxt  = ((i_blk_index == 5'h00) ? 32'h0 : sh_r) | (32'(i_blk[1]) << i_blk_index);
  assign line_d = {<<{i_blk[65:2]}};
  assign c_nxt  = sbf_crc_step((i_blk_index == 5'h00) ? 12'h000 : crc_r, line_d);
  assign rx_crc = {w_nxt[0], w_nxt[1], w_nxt[2], w_nxt[4], w_nxt[5], w_nxt[6],
                   w_nxt[8], w_nxt[9], w_nxt[10], w_nxt[12], w_nxt[13], w_nxt[14]};

  // collect the stream; only a single-shot flag, no realignment once lost
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_r       <= 32'h0;
      crc_r      <= 12'h000;
      crc_prev_r <= 12'h000;
      o_word     <= 32'h0;
      o_hdr_bad  <= 1'b0;
      o_crc_err  <= 1'b0;
    end else if (i_blk_valid) begin
      sh_r  <= w_nxt;
      crc_r <= c_nxt;
      if (i_blk[1] == i_blk[0]) begin
        o_hdr_bad <= 1'b1;
      end
      if (i_blk_index == 5'h1F) begin
        o_word     <= w_nxt;
        crc_prev_r <= c_nxt;
        if (i_crc_mode && (rx_crc != crc_prev_r)) begin
          o_crc_err <= 1'b1;
        end
      end
    end
  end
endmodule

/* dv/sbf_block_framer_bench.sv */
module sbf_block_framer_bench
  import sbf_dv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst_n = 0, sref_in = 0, vin = 0, crc_mode = 1; // drives, all live
  logic [63:0] din = '0;
  logic [1:0]  fmt = 0, nfmt = 0;  // applied format, and format for the next multiblock
  logic [4:0]  esz = 0, bi = 0, mi = 0, pbi = 0, pmi = 0;
  logic [25:0] fec = 0, prev_fec = 0;
  logic [11:0] cur_crc = 0, prev_crc = 0;
  logic [31:0] cw = 0, exp_w = 0, rx_word;
  logic [65:0] o_blk, pblk = 0;
  logic        o_blk_valid, o_lemc_pulse, o_aligned, rx_bad, rx_err, pv = 0;
  logic [4:0]  o_blk_index, o_mb_index;
  int          n_mismatch = 0, checks_done = 0, wp = 0, seed;

  always #10 clk = ~clk;

  sbf_block_framer DUT (.i_mclk(clk), .i_rst_n(rst_n), .i_sysref(sref_in), .i_blk_data(din),
    .i_blk_valid(vin), .i_sync_header_format_select(fmt), .i_emb_size_e(esz), .i_fec_parity(fec),
    .o_blk(o_blk), .o_blk_valid(o_blk_valid), .o_blk_index(o_blk_index), .o_mb_index(o_mb_index),
    .o_lemc_pulse(o_lemc_pulse), .o_aligned(o_aligned));
  sbf_rx_model RX (.i_mclk(clk), .i_rst_n(rst_n), .i_blk(o_blk), .i_blk_valid(o_blk_valid),
    .i_blk_index(o_blk_index), .i_crc_mode(crc_mode), .o_word(rx_word), .o_hdr_bad(rx_bad),
    .o_crc_err(rx_err));

  task automatic chk(input string what, input logic [65:0] exp, input logic [65:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // expected stream word of a multiblock from what the bench itself sent
  function automatic logic [31:0] exp_word(input logic [1:0] f, input logic [11:0] c,
                                           input logic [25:0] q, input logic eo);
    logic [31:0] w;
    if (f == 2'h2) begin
      w = 32'h80000000; // pilot tail only
      for (int i = 0; i < 22; i++) w[i] = q[25-i];
      for (int j = 0; j < 4; j++) w[23+j] = q[3-j];
    end else begin
      w = 32'h80A88888; // fixed ones, command bits zero
      for (int k = 0; k < 12; k++) w[k+k/3] = c[11-k];
    end
    w[22] = eo;
    return w;
  endfunction

  // one clock: check what the last taken block produced, then offer the next one
  task automatic step(input logic v);
    logic [63:0] rev;
    @(negedge clk);
    if (wp != 0) begin
      wp--;
      if (wp == 0) chk("stream word", exp_w, rx_word);
    end
    if (pv) begin
      chk("block", pblk, o_blk);
      chk("block index", pbi, o_blk_index);
      chk("mb index", pmi, o_mb_index);
      chk("lemc", (pbi == 0 && pmi == 0), o_lemc_pulse);
    end
    chk("valid", pv, o_blk_valid);
    pv  = v;
    vin = v;
    if (v) begin
      din = {$urandom, $urandom};
      fec = 26'($urandom);
      if (bi == 0) begin
        fmt = nfmt;
        cw  = exp_word(nfmt, prev_crc, prev_fec, mi == esz);
      end
      rev     = {<<{din}};
      pblk    = {rev, cw[bi], ~cw[bi]};
      pbi     = bi;
      pmi     = mi;
      cur_crc = sbf_crc_step((bi == 0) ? 12'h000 : cur_crc, din);
      if (bi == 5'h1F) begin
        wp       = 2;
        exp_w    = cw;
        crc_mode = (fmt != 2'h2);
        prev_crc = cur_crc;
        prev_fec = fec;
        mi       = (mi == esz) ? 5'h00 : mi + 5'h01;
      end
      bi++;
    end
  endtask

  // n multiblocks, back to back or with random idle cycles
  task automatic run(input int n, input bit dense);
    int k;
    int guard;
    bit v;
    k = 0;
    guard = 0;
    while (k < 32 * n) begin
      guard++;
      if (guard > 256 * n) begin
        chk("run blocks", 66'(32 * n), 66'(k));
        conclude;
      end
      v = dense || ($urandom_range(3) != 0);
      step(v);
      if (v) k++;
    end
    repeat (3) step(1'b0);
  endtask

  // single sysref pulse, long enough for the synchroniser; restarts timing at block 0
  // busy keeps blocks flowing, so the block offered as the edge fires must become block 0
  task automatic sref(input bit busy);
    @(negedge clk);
    sref_in = 1'b1;
    step(busy);
    step(busy);
    bi = 0;
    mi = 0;
    step(busy);
    sref_in = 1'b0;
    repeat (2) step(1'b0);
    chk("aligned", 1'b1, o_aligned);
  endtask

  initial begin
    seed = $urandom(32'h6A49);
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("reset block", 66'h1, o_blk);
    chk("reset flags", 66'h0, {o_blk_valid, o_lemc_pulse, o_aligned, o_blk_index, o_mb_index});
    sref(1'b0);
    for (int f = 0; f < 4; f++) begin
      nfmt = 2'(f);
      run(1, 1'b1);
    end
    esz = 5'h02;
    for (int m = 0; m < 6; m++) begin
      if (m == 2) sref(1'b1); // rephase in mid extended multiblock
      nfmt = 2'($urandom_range(3));
      run(1, 1'b0);
    end
    chk("rx header", 66'h0, rx_bad);
    chk("rx parity", 66'h0, rx_err);
    conclude;
  end
endmodule
